// file: bench/crc_checksum_engine_bench.sv
// Purpose: self-checking bench for the crc checksum engine register port
// Assumes: bench drives every input itself, strobes by nba right after a rising edge
// Notes:   expected crc values come from a bench-side bitwise model
`timescale 1ns/100ps
module crc_checksum_engine_bench
  import cce_pkg::*;
;
  logic        i_clk;
  logic        i_rst_n;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_busy;
  logic        o_in_ready;
  int          err_total = 0;
  int          compares  = 0;
  int          cyc       = 0;
  int          full_cnt  = 0;

  cce_top u_dut (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .o_busy     (o_busy),
    .o_in_ready (o_in_ready)
  );

  always #2 i_clk = ~i_clk;

  // all tests fit in well under a thousand cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end

  always @(negedge i_clk) begin
    if (o_in_ready === 1'b0) begin
      full_cnt <= full_cnt + 1;
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // two reads back to back, strobe held high over both
  task automatic rd2(input logic [3:0] a, output logic [31:0] d0, output logic [31:0] d1);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    #1 d0 = o_rdata;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d1 = o_rdata;
  endtask

  function automatic logic [31:0] rev(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  // non-reflected crc, low byte first, each byte msb first
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d,
                                          input int nb, input logic p32);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int b = 0; b < nb; b++) begin
      for (int i = 7; i >= 0; i--) begin
        fb = (p32 ? r[31] : r[15]) ^ d[8*b+i];
        r  = r << 1;
        if (!p32) begin
          r[31:16] = 16'h0000;
        end
        if (fb) begin
          r = r ^ (p32 ? CCE_POLY32 : {16'h0000, CCE_POLY16});
        end
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctl(input logic en, input logic p32, input logic [1:0] bt);
    return (32'(en) << CCE_CTRL_EN_BIT) | (32'(p32) << CCE_CTRL_POLY_BIT) |
           (32'(bt) << CCE_CTRL_BEAT_LSB);
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    @(posedge i_clk);
    rd(CCE_OFF_CHK, d);
    chk(d, CCE_RST_CHK);
    @(posedge i_clk);
    rd(CCE_OFF_DIN, d);
    chk(d, CCE_RST_DIN);
    @(posedge i_clk);
    rd(CCE_OFF_STAT, d);
    chk(d, 32'h1 << CCE_STAT_RDY_BIT);
    @(posedge i_clk);
    rd(4'h1, d);
    chk(d, 32'h00000000);
    @(posedge i_clk);
    wr(CCE_OFF_DIN, 32'hA5C3_0F96);
    rd(CCE_OFF_DIN, d);
    chk(d, 32'hA5C3_0F96);
    @(posedge i_clk);
    rd(CCE_OFF_CHK, d);
    chk(d, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_seed();
    logic [31:0] d;
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b0, 1'b0, 2'h0));
    @(posedge i_clk);
    wr(CCE_OFF_CHK, 32'h1234_5678);
    rd(CCE_OFF_CHK, d);
    chk(d, 32'h0000_5678);
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b0, 1'b1, 2'h0));
    @(posedge i_clk);
    wr(CCE_OFF_CHK, 32'h1234_5678);
    rd(CCE_OFF_CHK, d);
    chk(d, ~rev(32'h1234_5678));
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b1, 1'b1, 2'h0));
    @(posedge i_clk);
    wr(CCE_OFF_CHK, 32'h0000_0000);
    rd(CCE_OFF_CHK, d);
    chk(d, ~rev(32'h1234_5678));
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b0, 1'b1, 2'h3));
    rd(CCE_OFF_CTRL, d);
    chk(d, ctl(1'b0, 1'b1, 2'h2));
    $display("test seed done");
  endtask

  task automatic t_fold(input logic p32, input logic [1:0] bt, input logic [31:0] seed,
                        input logic [31:0] din);
    logic [31:0] d0;
    logic [31:0] d;
    logic [31:0] s;
    logic [31:0] e;
    s = p32 ? seed : {16'h0000, seed[15:0]};
    e = crc_ref(s, din, 1 << bt, p32);
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b0, p32, bt));
    @(posedge i_clk);
    wr(CCE_OFF_CHK, seed);
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b1, p32, bt));
    @(posedge i_clk);
    wr(CCE_OFF_DIN, din);
    // word taken one edge after the write, result lands after beat plus one busy cycles
    if (bt == 2'h2) begin
      @(posedge i_clk);
      rd2(CCE_OFF_CHK, d0, d);
      chk(d0, s);
      chk(d, s);
      @(posedge i_clk);
      rd(CCE_OFF_CHK, d);
    end else begin
      repeat (bt + 2) @(posedge i_clk);
      rd(CCE_OFF_CHK, d);
    end
    chk(d, p32 ? ~rev(e) : e);
    chk({31'h0, o_busy}, 32'h0);
    $display("test fold beat %0d done", bt);
  endtask

  task automatic t_abort();
    logic [31:0] d;
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b0, 1'b1, 2'h2));
    @(posedge i_clk);
    wr(CCE_OFF_CHK, 32'hFFFF_FFFF);
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b1, 1'b1, 2'h2));
    @(posedge i_clk);
    wr(CCE_OFF_DIN, 32'h1357_9BDF);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= CCE_OFF_CTRL;
    i_wdata <= ctl(1'b0, 1'b1, 2'h2);
    #1 chk({31'h0, o_busy}, 32'h1);
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1 chk({31'h0, o_busy}, 32'h0);
    @(posedge i_clk);
    rd(CCE_OFF_CHK, d);
    chk(d, ~rev(32'hFFFF_FFFF));
    $display("test abort done");
  endtask

  // word beats arrive faster than the engine folds them
  task automatic t_fill();
    logic [31:0] d;
    int          seen;
    @(posedge i_clk);
    wr(CCE_OFF_CTRL, ctl(1'b1, 1'b1, 2'h2));
    @(posedge i_clk);
    seen   = full_cnt;
    i_wr   <= 1'b1;
    i_addr <= CCE_OFF_DIN;
    for (int k = 0; k < 6; k++) begin
      i_wdata <= 32'(k);
      @(posedge i_clk);
    end
    i_wr <= 1'b0;
    repeat (40) @(posedge i_clk);
    // two queued words plus one in the engine: full for three cycles
    chk(32'(full_cnt - seen), 32'h3);
    rd(CCE_OFF_STAT, d);
    chk(d, 32'h1 << CCE_STAT_RDY_BIT);
    $display("test fill done");
  endtask

  initial begin
    i_clk   = 1'b0;
    i_rst_n = 1'b0;
    i_addr  = 4'h0;
    i_wdata = 32'h00000000;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_reset();
    t_seed();
    t_fold(1'b1, 2'h0, 32'hFFFF_FFFF, 32'h0000_0031);
    t_fold(1'b1, 2'h1, 32'hFFFF_FFFF, 32'h0000_A231);
    t_fold(1'b1, 2'h2, 32'hFFFF_FFFF, 32'h3433_3231);
    t_fold(1'b0, 2'h1, 32'h0000_FFFF, 32'h0000_3231);
    t_fold(1'b0, 2'h2, 32'h0000_1D0F, 32'hDEAD_BEEF);
    t_abort();
    t_fill();
    finish_test();
  end
endmodule

// file: include/cce_pkg.sv
// Purpose: shared constants and types of the checksum engine
// Assumes: byte addresses on a 4-bit register port
// Notes:   every offset and field position lives here, with the din and chk reset values
package cce_pkg;

  // register byte offsets
  localparam logic [3:0] CCE_OFF_CTRL = 4'h0;
  localparam logic [3:0] CCE_OFF_DIN  = 4'h4;
  localparam logic [3:0] CCE_OFF_CHK  = 4'h8;
  localparam logic [3:0] CCE_OFF_STAT = 4'hC;

  // control field positions
  localparam int CCE_CTRL_EN_BIT   = 0;
  localparam int CCE_CTRL_POLY_BIT = 1;
  localparam int CCE_CTRL_BEAT_LSB = 2;

  // status field positions
  localparam int CCE_STAT_BUSY_BIT = 0;
  localparam int CCE_STAT_RDY_BIT  = 1;
  localparam int CCE_STAT_LVL_LSB  = 2;

  // reset values
  localparam logic [31:0] CCE_RST_DIN = 32'h00000000;
  localparam logic [31:0] CCE_RST_CHK = 32'h00000000;

  // generator polynomials, msb-first form
  localparam logic [31:0] CCE_POLY32 = 32'h04C11DB7;
  localparam logic [15:0] CCE_POLY16 = 16'h1021;

  // cycles beyond the beat setting until the checksum is valid
  localparam int CCE_LAT_EXTRA = 1;

  typedef enum logic [1:0] {
    CCE_BEAT_BYTE = 2'b00,
    CCE_BEAT_HALF = 2'b01,
    CCE_BEAT_WORD = 2'b10
  } cce_beat_t;

  typedef enum logic {
    CCE_IDLE = 1'b0,
    CCE_RUN  = 1'b1
  } cce_eng_t;

  function automatic logic [31:0] cce_bitrev(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

endpackage

// file: include/cce_stream_if.sv
// Purpose: valid/ready word channel between buffer and engine
// Assumes: single clock domain
// Notes:   a word moves on a cycle with valid and ready both high
`timescale 1ns/100ps
interface cce_stream_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: verilog/cce_buf.sv
// Purpose: small valid/ready word buffer in front of the engine
// Assumes: depth is a power of two, at least two
// Notes:   flush empties it in one cycle; ready is a flop
`timescale 1ns/100ps
module cce_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  // fill side
  input  wire logic           i_flush,
  input  wire logic           i_valid,
  input  wire logic [W-1:0]   i_data,
  output logic                o_ready,
  output logic [$clog2(DEPTH):0] o_level,
  // drain side
  cce_stream_if.src           out_if
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("buffer depth must be a power of two of at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ready;
  } cce_buf_st_t;

  localparam cce_buf_st_t RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, ready: 1'b1};

  cce_buf_st_t st_ff;
  cce_buf_st_t nxt_st;
  logic        push;
  logic        pop;

  assign out_if.valid = (st_ff.cnt != '0);
  assign out_if.data  = st_ff.mem[st_ff.rp];
  assign o_ready      = st_ff.ready;
  assign o_level      = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    push   = i_valid && st_ff.ready;
    pop    = out_if.valid && out_if.ready;
    if (push) begin
      nxt_st.mem[st_ff.wp] = i_data;
      nxt_st.wp            = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // a disabled engine owns no queued words
    if (i_flush) begin
      nxt_st.wp  = '0;
      nxt_st.rp  = '0;
      nxt_st.cnt = '0;
    end
    nxt_st.ready = (nxt_st.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  full_blocks_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_ff.cnt == (AW+1)'(DEPTH)) |-> !st_ff.ready)
    else $error("buffer full but still ready");

endmodule

// file: verilog/cce_crc_fold.sv
// Purpose: folds 1, 2 or 4 low-first bytes into a running crc
// Assumes: each byte enters msb first
// Notes:   purely combinational; 16-bit mode keeps the upper half at zero
`timescale 1ns/100ps
module cce_crc_fold
  import cce_pkg::*;
(
  // operands
  input  wire logic [31:0] i_crc,
  input  wire logic [31:0] i_data,
  input  wire cce_beat_t   i_beat,
  input  wire logic        i_poly32,
  // result
  output logic      [31:0] o_crc
);

  logic [31:0] c;
  logic        fb;
  int          nb;

  always_comb begin
    c  = i_crc;
    fb = 1'b0;
    case (i_beat)
      CCE_BEAT_BYTE: nb = 1;
      CCE_BEAT_HALF: nb = 2;
      default:       nb = 4;
    endcase
    for (int b = 0; b < 4; b++) begin
      for (int k = 7; k >= 0; k--) begin
        if (b < nb) begin
          if (i_poly32) begin
            fb = c[31] ^ i_data[8*b+k];
            c  = {c[30:0], 1'b0} ^ (fb ? CCE_POLY32 : 32'h00000000);
          end else begin
            fb = c[15] ^ i_data[8*b+k];
            c  = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, (fb ? CCE_POLY16 : 16'h0000)};
          end
        end
      end
    end
    o_crc = c;
  end

endmodule

// file: verilog/cce_top.sv
// Purpose: crc checksum engine with a simple register port
// Assumes: strobes are one cycle, never together, from the i_clk domain
// Notes:   read data stand one cycle after the read strobe only
`timescale 1ns/100ps
module cce_top
  import cce_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // status
  output logic             o_busy,
  output logic             o_in_ready
);

  localparam int LW = $clog2(BUF_DEPTH) + 1;

  if (BUF_DEPTH < 2 || LW > 6) begin : g_bad_depth
    $error("buffer depth out of range for the status register");
  end

  typedef struct packed {
    logic        en;
    logic        poly32;
    cce_beat_t   beat;
    logic [31:0] din;
    logic [31:0] chk;
    cce_eng_t    eng;
    logic [1:0]  cnt;
    logic [31:0] work;
    cce_beat_t   wbeat;
    logic        wpoly;
    logic [31:0] rdata;
  } cce_state_t;

  localparam cce_state_t RST = '{
    en: 1'b0, poly32: 1'b0, beat: CCE_BEAT_BYTE, din: CCE_RST_DIN, chk: CCE_RST_CHK,
    eng: CCE_IDLE, cnt: 2'h0, work: 32'h00000000, wbeat: CCE_BEAT_BYTE, wpoly: 1'b0,
    rdata: 32'h00000000};

  logic          rst_meta_ff;
  logic          rst_sync_ff;
  cce_state_t    st_ff;
  cce_state_t    nxt_st;
  logic          buf_ready;
  logic [LW-1:0] buf_level;
  logic [31:0]   fold_crc;
  logic [31:0]   chk_view;
  logic          wr_hit;
  logic          rd_hit;
  logic          start;
  logic          commit;
  logic          din_push;

  cce_stream_if #(.W(32)) buf_if ();

  // release is synchronised so all flops leave reset on the same edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  cce_buf #(
    .W     (32),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (rst_sync_ff),
    .i_flush (!st_ff.en),
    .i_valid (din_push),
    .i_data  (i_wdata),
    .o_ready (buf_ready),
    .o_level (buf_level),
    .out_if  (buf_if.src)
  );

  cce_crc_fold u_fold (
    .i_crc    (st_ff.chk),
    .i_data   (st_ff.work),
    .i_beat   (st_ff.wbeat),
    .i_poly32 (st_ff.wpoly),
    .o_crc    (fold_crc)
  );

  assign wr_hit   = i_wr && (i_addr[1:0] == 2'b00);
  assign rd_hit   = i_rd && (i_addr[1:0] == 2'b00);
  // words written while disabled are stored but never folded
  assign din_push = wr_hit && (i_addr == CCE_OFF_DIN) && st_ff.en;
  assign start    = st_ff.en && (st_ff.eng == CCE_IDLE) && buf_if.valid;
  assign commit   = (st_ff.eng == CCE_RUN) && (st_ff.cnt == 2'h0);
  assign buf_if.ready = start;

  // reversed and inverted view once idle
  // raw view in 16-bit mode or while busy
  always_comb begin
    if (st_ff.poly32 && st_ff.eng == CCE_IDLE) begin
      chk_view = ~cce_bitrev(st_ff.chk);
    end else if (st_ff.poly32) begin
      chk_view = st_ff.chk;
    end else begin
      chk_view = {16'h0000, st_ff.chk[15:0]};
    end
  end

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 32'h00000000;

    if (wr_hit && i_addr == CCE_OFF_CTRL) begin
      nxt_st.en     = i_wdata[CCE_CTRL_EN_BIT];
      nxt_st.poly32 = i_wdata[CCE_CTRL_POLY_BIT];
      // reserved beat code falls back to a word
      if (i_wdata[CCE_CTRL_BEAT_LSB+:2] == 2'b11) begin
        nxt_st.beat = CCE_BEAT_WORD;
      end else begin
        nxt_st.beat = cce_beat_t'(i_wdata[CCE_CTRL_BEAT_LSB+:2]);
      end
    end

    if (wr_hit && i_addr == CCE_OFF_DIN) begin
      nxt_st.din = i_wdata;
    end

    case (st_ff.eng)
      CCE_IDLE: begin
        // busy for beat plus one cycles
        if (start) begin
          nxt_st.eng   = CCE_RUN;
          nxt_st.cnt   = st_ff.beat;
          nxt_st.work  = buf_if.data;
          nxt_st.wbeat = st_ff.beat;
          nxt_st.wpoly = st_ff.poly32;
        end
      end
      CCE_RUN: begin
        if (st_ff.cnt == 2'h0) begin
          // 16-bit result keeps the upper half clear
          nxt_st.chk = st_ff.wpoly ? fold_crc : {16'h0000, fold_crc[15:0]};
          nxt_st.eng = CCE_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt - 2'h1;
        end
      end
      default: begin
        nxt_st.eng = CCE_IDLE;
      end
    endcase

    if (wr_hit && i_addr == CCE_OFF_CHK && !st_ff.en) begin
      nxt_st.chk = st_ff.poly32 ? i_wdata : {16'h0000, i_wdata[15:0]};
    end

    if (!nxt_st.en) begin
      nxt_st.eng = CCE_IDLE;
    end

    if (rd_hit) begin
      case (i_addr)
        CCE_OFF_CTRL: begin
          nxt_st.rdata[CCE_CTRL_EN_BIT]        = st_ff.en;
          nxt_st.rdata[CCE_CTRL_POLY_BIT]      = st_ff.poly32;
          nxt_st.rdata[CCE_CTRL_BEAT_LSB+:2]   = st_ff.beat;
        end
        CCE_OFF_DIN: begin
          nxt_st.rdata = st_ff.din;
        end
        CCE_OFF_CHK: begin
          nxt_st.rdata = chk_view;
        end
        CCE_OFF_STAT: begin
          nxt_st.rdata[CCE_STAT_BUSY_BIT]      = (st_ff.eng == CCE_RUN);
          nxt_st.rdata[CCE_STAT_RDY_BIT]       = buf_ready;
          nxt_st.rdata[CCE_STAT_LVL_LSB+:LW]   = buf_level;
        end
        default: begin
          nxt_st.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata    = st_ff.rdata;
  assign o_busy     = st_ff.eng;
  assign o_in_ready = buf_ready;

  // helper: cycles spent in the run state
  logic [2:0] run_cyc_ff;

  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      run_cyc_ff <= 3'h0;
    end else if (st_ff.eng == CCE_RUN) begin
      run_cyc_ff <= run_cyc_ff + 3'h1;
    end else begin
      run_cyc_ff <= 3'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_sync_ff);

  din_store_a: assert property (
    (wr_hit && i_addr == CCE_OFF_DIN) |=> (st_ff.din == $past(i_wdata)))
    else $error("input word not stored");

  start_lat_a: assert property (
    (din_push && buf_ready && buf_level == '0 && st_ff.eng == CCE_IDLE)
      |=> (start && st_ff.eng == CCE_IDLE))
    else $error("queued word not taken next cycle");

  run_len_a: assert property (
    commit |-> (run_cyc_ff == {1'b0, st_ff.wbeat} && CCE_LAT_EXTRA == 1))
    else $error("computation length differs from beat setting");

  raw16_width_a: assert property (
    (rd_hit && i_addr == CCE_OFF_CHK && !st_ff.poly32) |=> (o_rdata[31:16] == 16'h0000))
    else $error("16-bit checksum read shows upper bits");

  seed_write_a: assert property (
    (wr_hit && i_addr == CCE_OFF_CHK && !st_ff.en && st_ff.poly32)
      |=> (st_ff.chk == $past(i_wdata)))
    else $error("seed write not taken while disabled");

  enabled_protect_a: assert property (
    (wr_hit && i_addr == CCE_OFF_CHK && st_ff.en && !commit) |=> $stable(st_ff.chk))
    else $error("checksum changed by write while enabled");

  rev_read_a: assert property (
    (rd_hit && i_addr == CCE_OFF_CHK && st_ff.poly32 && st_ff.eng == CCE_IDLE)
      |=> (o_rdata == ~cce_bitrev($past(st_ff.chk))))
    else $error("32-bit idle read not reversed and inverted");

  raw_read_a: assert property (
    (rd_hit && i_addr == CCE_OFF_CHK && st_ff.poly32 && st_ff.eng == CCE_RUN)
      |=> (o_rdata == $past(st_ff.chk)))
    else $error("busy read not raw");

  abort_busy_a: assert property (
    (!st_ff.en) |-> (st_ff.eng == CCE_IDLE && !o_busy))
    else $error("busy while disabled");

  beat_legal_a: assert property (
    (st_ff.beat != 2'b11) && (st_ff.wbeat != 2'b11))
    else $error("reserved beat code held");

  start_busy_a: assert property (
    (start && !(wr_hit && i_addr == CCE_OFF_CTRL)) |=> o_busy)
    else $error("engine did not turn busy on start");

  start_load_a: assert property (
    start |=> (st_ff.cnt == st_ff.wbeat))
    else $error("run length not loaded from beat setting");

  idle_stay_a: assert property (
    (st_ff.eng == CCE_IDLE && !start) |=> !o_busy)
    else $error("busy set with no computation");

  // a disable in the commit cycle still lands that result, so it is left out here
  abort_keep_a: assert property (
    (wr_hit && i_addr == CCE_OFF_CTRL && !i_wdata[CCE_CTRL_EN_BIT] && o_busy && !commit)
      |=> (!o_busy && $stable(st_ff.chk)))
    else $error("abort left busy set or committed a result");

  run_bound_a: assert property (
    (st_ff.eng == CCE_RUN) |-> (run_cyc_ff <= {1'b0, st_ff.wbeat}))
    else $error("computation ran past its beat setting");

  narrow_commit_a: assert property (
    (commit && !st_ff.wpoly) |=> (st_ff.chk[31:16] == 16'h0000))
    else $error("16-bit result left upper bits set");

  seed_narrow_a: assert property (
    (wr_hit && i_addr == CCE_OFF_CHK && !st_ff.en && !st_ff.poly32)
      |=> (st_ff.chk == {16'h0000, $past(i_wdata[15:0])}))
    else $error("16-bit seed not stored in the low half");

  idle_hold_a: assert property (
    (st_ff.eng == CCE_IDLE && !(wr_hit && i_addr == CCE_OFF_CHK)) |=> $stable(st_ff.chk))
    else $error("checksum changed with no commit or seed");

  view16_read_a: assert property (
    (rd_hit && i_addr == CCE_OFF_CHK && !st_ff.poly32)
      |=> (o_rdata == {16'h0000, $past(st_ff.chk[15:0])}))
    else $error("16-bit read not raw");

  din_read_a: assert property (
    (rd_hit && i_addr == CCE_OFF_DIN) |=> (o_rdata == $past(st_ff.din)))
    else $error("input word read back wrong");

  stat_busy_a: assert property (
    (rd_hit && i_addr == CCE_OFF_STAT) |=> (o_rdata[CCE_STAT_BUSY_BIT] == $past(o_busy)))
    else $error("status busy bit differs from busy flag");

  flush_empty_a: assert property (
    (!st_ff.en) |=> (buf_level == '0))
    else $error("queued words kept after disable");

  beat_latch_a: assert property (
    (st_ff.eng == CCE_RUN && st_ff.cnt != 2'h0)
      |=> ($stable(st_ff.wbeat) && $stable(st_ff.work) && $stable(st_ff.wpoly)))
    else $error("beat setting or word changed during a run");

  beat_fold_a: assert property (
    (wr_hit && i_addr == CCE_OFF_CTRL && i_wdata[CCE_CTRL_BEAT_LSB+:2] == 2'b11)
      |=> (st_ff.beat == CCE_BEAT_WORD))
    else $error("reserved beat code not stored as a word");

endmodule
